// *** rtl/csfl_defines.svh ***
// constants of the cpu status flag logic
`ifndef CSFL_DEFINES_SVH
`define CSFL_DEFINES_SVH
// ****************************************
// register map and reset
// ****************************************
`define CSFL_FLAGS_ADDR 8'hd5
`define CSFL_FLAGS_RST  8'h00
// ****************************************
// field positions in the condition register
// ****************************************
`define CSFL_C   7
`define CSFL_Z   6
`define CSFL_S   5
`define CSFL_V   4
`define CSFL_D   3
`define CSFL_H   2
`define CSFL_FIS 1
`define CSFL_BA  0
// ****************************************
// condition field codes
// ****************************************
`define CSFL_CC_TRUE 4'h8
`define CSFL_CC_C    4'h7
`define CSFL_CC_Z    4'h6
`define CSFL_CC_MI   4'h5
`endif

// *** rtl/csfl_flag_calc.sv ***
// next value of the condition register for one operation
`timescale 1ns/1ns
`default_nettype none
`include "csfl_defines.svh"
module csfl_flag_calc (
  csfl_if.calc f
);
  // ****************************************
  // adder view of add and subtract
  // ****************************************
  wire       is_sub = (f.op == csfl_pkg::OP_SUB) | (f.op == csfl_pkg::OP_SBC);
  wire       use_c  = (f.op == csfl_pkg::OP_ADC) | (f.op == csfl_pkg::OP_SBC);
  wire       cin    = use_c & f.base[`CSFL_C];
  wire [7:0] b_eff  = is_sub ? ~f.b : f.b;
  wire       ci     = is_sub ? ~cin : cin;
  wire [8:0] sum9   = {1'b0, f.a} + {1'b0, b_eff} + {8'h00, ci};
  wire [4:0] nib5   = {1'b0, f.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, ci};
  // borrow is the inverted carry of a + ~b + 1
  wire       cy     = is_sub ? ~sum9[8] : sum9[8];
  wire       hc     = is_sub ? ~nib5[4] : nib5[4];
  wire       ovf    = (f.a[7] == b_eff[7]) & (sum9[7] != f.a[7]);
  wire       az     = (sum9[7:0] == 8'h00);
  wire       rz     = (f.res == 8'h00);
  wire       arith  = (f.op == csfl_pkg::OP_ADD) | (f.op == csfl_pkg::OP_ADC) |
                      is_sub;

  always_comb begin
    f.next_flags = f.base;
    if (arith) begin
      f.next_flags[`CSFL_C] = cy;      // [RQ5]
      f.next_flags[`CSFL_Z] = az;      // [RQ8]
      f.next_flags[`CSFL_S] = sum9[7]; // [RQ9]
      f.next_flags[`CSFL_V] = ovf;     // [RQ10]
      f.next_flags[`CSFL_D] = is_sub;  // [RQ12]
      f.next_flags[`CSFL_H] = hc;      // [RQ13]
    end
    case (f.op)
      csfl_pkg::OP_LOGIC, csfl_pkg::OP_BTST: begin
        f.next_flags[`CSFL_Z] = rz;      // [RQ4] [RQ8]
        f.next_flags[`CSFL_S] = f.res[7]; // [RQ9]
        f.next_flags[`CSFL_V] = 1'b0;    // [RQ11]
      end
      csfl_pkg::OP_SHIFT: begin
        f.next_flags[`CSFL_C] = f.shout;  // [RQ6]
        f.next_flags[`CSFL_Z] = rz;       // [RQ8]
        f.next_flags[`CSFL_S] = f.res[7]; // [RQ9]
      end
      csfl_pkg::OP_DADJ: begin
        // adjust carry comes from the alu on the shift-out line
        f.next_flags[`CSFL_C] = f.shout;
        f.next_flags[`CSFL_Z] = rz;
        f.next_flags[`CSFL_S] = f.res[7];
      end
      csfl_pkg::OP_SCF: f.next_flags[`CSFL_C] = 1'b1;  // [RQ7]
      csfl_pkg::OP_RCF: f.next_flags[`CSFL_C] = 1'b0;  // [RQ7]
      csfl_pkg::OP_CCF: f.next_flags[`CSFL_C] = ~f.base[`CSFL_C]; // [RQ7]
      csfl_pkg::OP_SB0: f.next_flags[`CSFL_BA] = 1'b0; // [RQ17]
      csfl_pkg::OP_SB1: f.next_flags[`CSFL_BA] = 1'b1; // [RQ17]
      csfl_pkg::OP_INTERRUPT_RETURN: f.next_flags[`CSFL_FIS] = 1'b0; // [RQ14]
      default: ;
    endcase
  end
endmodule
`default_nettype wire

// *** rtl/csfl_if.sv ***
// carrier between the flag core and its two helpers
`timescale 1ns/1ns
`default_nettype none
interface csfl_if;
  csfl_pkg::csfl_op_t op;
  logic [7:0]         a;
  logic [7:0]         b;
  logic [7:0]         res;
  logic               shout;
  logic [7:0]         base;
  logic [7:0]         next_flags;
  logic [3:0]         wreg;
  logic [2:0]         bsel;
  logic [7:0]         pair;
  logic [7:0]         roff;
  logic [7:0]         soff;
  logic [15:0]        loff;
  logic               is_long;
  logic [15:0]        npc;
  logic [15:0]        ibase;
  logic [15:0]        wreg_sel;
  logic [7:0]         bmask;
  logic               pair_ok;
  logic [15:0]        btgt;
  logic [15:0]        iaddr;
  modport calc (input op, a, b, res, shout, base, output next_flags);
  modport opnd (input wreg, bsel, pair, roff, soff, loff, is_long, npc,
                ibase, output wreg_sel, bmask, pair_ok, btgt, iaddr);
endinterface
`default_nettype wire

// *** rtl/csfl_operand.sv ***
// operand field decode: selects, pairs, branch and index targets
`timescale 1ns/1ns
`default_nettype none
module csfl_operand (
  csfl_if.opnd o
);
  genvar i;
  // ****************************************
  // one-hot selects
  // ****************************************
  generate
    for (i = 0; i < 16; i++) begin : g_wreg
      assign o.wreg_sel[i] = (o.wreg == 4'(i)); // [RQ18]
    end
    for (i = 0; i < 8; i++) begin : g_bit
      assign o.bmask[i] = (o.bsel == 3'(i)); // [RQ18]
    end
  endgenerate
  // ****************************************
  // pairs and address arithmetic
  // ****************************************
  assign o.pair_ok = ~o.pair[0]; // [RQ19]
  // offsets wrap modulo 64k like the program counter
  assign o.btgt  = o.npc + {{8{o.roff[7]}}, o.roff}; // [RQ20]
  assign o.iaddr = o.ibase + (o.is_long ? o.loff
                                        : {{8{o.soff[7]}}, o.soff}); // [RQ21]
endmodule
`default_nettype wire

// *** rtl/csfl_pkg.sv ***
// types of the cpu status flag logic
`default_nettype none
package csfl_pkg;
  // flag affecting operation classes, from the sequencer
  typedef enum logic [3:0] {
    OP_NOP   = 4'h0,
    OP_ADD   = 4'h1,
    OP_ADC   = 4'h2,
    OP_SUB   = 4'h3,
    OP_SBC   = 4'h4,
    OP_LOGIC = 4'h5,
    OP_BTST  = 4'h6,
    OP_SHIFT = 4'h7,
    OP_SCF   = 4'h8,
    OP_RCF   = 4'h9,
    OP_CCF   = 4'ha,
    OP_SB0   = 4'hb,
    OP_SB1   = 4'hc,
    OP_INTERRUPT_RETURN  = 4'hd,
    OP_DADJ  = 4'he
  } csfl_op_t;
endpackage
`default_nettype wire

// *** rtl/csfl_top.sv ***
// condition register, flag update and operand decode of the cpu core
// Behaviour
// RQ1 - eight-bit register, four testable, two bcd flags
// RQ2 - loads write the register directly
// RQ3 - alu update with register destination undefined
// RQ4 - and updates zero, sign, overflow
// RQ5 - carry on carry or borrow at bit 7
// RQ6 - shift leaves last bit out in carry
// RQ7 - carry can be set, cleared, inverted
// RQ8 - zero flag marks zero result
// RQ9 - sign copies result msb
// RQ10 - overflow marks signed range exceeded
// RQ11 - logic ops clear overflow
// RQ12 - decimal flag records add or subtract
// RQ13 - half carry from bit 3 or 4
// RQ14 - fast irq status set, cleared by return
// RQ15 - fast status blocks irqs, selects fast return
// RQ16 - bank bit selects register bank
// RQ17 - bank instructions clear or set bank bit
// RQ18 - sixteen working registers, eight bit positions
// RQ19 - register pairs are even only
// RQ20 - signed branch offset from next instruction
// RQ21 - indexed short signed or long unsigned offset
// RQ22 - four-bit condition tested against c z s v
`timescale 1ns/1ns
`default_nettype none
`include "csfl_defines.svh"
module csfl_top (
  input  wire logic               clk,
  input  wire logic               arst_n,
  input  wire logic               ce,
  input  wire logic               op_valid,
  input  wire csfl_pkg::csfl_op_t op_code,
  input  wire logic [7:0]         op_a,
  input  wire logic [7:0]         op_b,
  input  wire logic [7:0]         op_res,
  input  wire logic               op_shout,
  input  wire logic               firq_begin,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  output logic [7:0]              reg_rdata,
  input  wire logic               cc_valid,
  input  wire logic [3:0]         cc_field,
  input  wire logic [3:0]         fld_wreg,
  input  wire logic [2:0]         fld_bit,
  input  wire logic [7:0]         fld_pair,
  input  wire logic [7:0]         fld_roff,
  input  wire logic [15:0]        fld_npc,
  input  wire logic [15:0]        fld_ibase,
  input  wire logic [7:0]         fld_soff,
  input  wire logic [15:0]        fld_loff,
  input  wire logic               fld_long,
  output logic [7:0]              flags,
  output logic                    bank_sel,
  output logic                    irq_block,
  output logic                    fast_return,
  output logic                    collide,
  output logic                    jump_taken,
  output logic [15:0]             wreg_sel,
  output logic [7:0]              bit_mask,
  output logic                    pair_ok,
  output logic [15:0]             branch_target,
  output logic [15:0]             index_addr
);
  // ****************************************
  // condition evaluation
  // ****************************************
  // bit 3 inverts, low bits pick the test; d and h never take part
  function automatic logic cc_eval(input logic [3:0] cc,
                                   input logic [7:0] fl);
    logic c;
    logic z;
    logic s;
    logic v;
    logic t;
    c = fl[`CSFL_C];
    z = fl[`CSFL_Z];
    s = fl[`CSFL_S];
    v = fl[`CSFL_V];
    case (cc[2:0])
      3'h0:    t = 1'b0;
      3'h1:    t = s ^ v;
      3'h2:    t = z | (s ^ v);
      3'h3:    t = c | z;
      3'h4:    t = v;
      3'h5:    t = s;
      3'h6:    t = z;
      3'h7:    t = c;
      default: t = 1'b0;
    endcase
    return t ^ cc[3];
  endfunction

  // ****************************************
  // helpers and decode
  // ****************************************
  csfl_if u_if ();

  csfl_flag_calc u_calc (
    .f (u_if.calc)
  );

  csfl_operand u_opnd (
    .o (u_if.opnd)
  );

  wire       addr_hit = (reg_addr == `CSFL_FLAGS_ADDR);
  wire       wr_hit   = reg_wr & addr_hit;
  wire       rd_hit   = reg_rd & addr_hit;
  wire       upd      = op_valid & (op_code != csfl_pkg::OP_NOP);
  wire       is_interrupt_return  = op_valid & (op_code == csfl_pkg::OP_INTERRUPT_RETURN);
  wire [7:0] base     = wr_hit ? reg_wdata : flags; // [RQ2]
  wire       cc_hit   = cc_eval(cc_field, flags); // [RQ22]
  logic [7:0] next_flags;

  assign u_if.op    = op_valid ? op_code : csfl_pkg::OP_NOP;
  assign u_if.a     = op_a;
  assign u_if.b     = op_b;
  assign u_if.res   = op_res;
  assign u_if.shout = op_shout;
  assign u_if.base  = base;
  assign u_if.wreg  = fld_wreg;
  assign u_if.bsel  = fld_bit;
  assign u_if.pair  = fld_pair;
  assign u_if.roff  = fld_roff;
  assign u_if.soff  = fld_soff;
  assign u_if.loff  = fld_loff;
  assign u_if.is_long = fld_long;
  assign u_if.npc   = fld_npc;
  assign u_if.ibase = fld_ibase;

  // a fast cycle starting with a return in flight keeps the bit set
  always_comb begin
    next_flags = u_if.next_flags;
    next_flags[`CSFL_FIS] = firq_begin | u_if.next_flags[`CSFL_FIS]; // [RQ14]
  end

  assign bank_sel  = flags[`CSFL_BA];  // [RQ16]
  assign irq_block = flags[`CSFL_FIS]; // [RQ15]

  // ****************************************
  // state
  // ****************************************
  // write and update in one cycle: update overlays the written value,
  // software must not rely on it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags <= `CSFL_FLAGS_RST;
    end else if (ce) begin
      flags <= next_flags; // [RQ1] [RQ3]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata   <= 8'h00;
      fast_return <= 1'b0;
      collide     <= 1'b0;
      jump_taken  <= 1'b0;
    end else if (ce) begin
      reg_rdata   <= rd_hit ? flags : 8'h00;
      fast_return <= is_interrupt_return & flags[`CSFL_FIS]; // [RQ15]
      collide     <= wr_hit & upd; // [RQ3]
      jump_taken  <= cc_valid & cc_hit; // [RQ22]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wreg_sel      <= 16'h0000;
      bit_mask      <= 8'h00;
      pair_ok       <= 1'b0;
      branch_target <= 16'h0000;
      index_addr    <= 16'h0000;
    end else if (ce) begin
      wreg_sel      <= u_if.wreg_sel; // [RQ18]
      bit_mask      <= u_if.bmask;
      pair_ok       <= u_if.pair_ok; // [RQ19]
      branch_target <= u_if.btgt; // [RQ20]
      index_addr    <= u_if.iaddr; // [RQ21]
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  wire       quiet = ce & ~wr_hit & ~firq_begin;
  wire [8:0] add9  = {1'b0, op_a} + {1'b0, op_b};
  wire [4:0] addn  = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]};
  wire [8:0] sadd  = {op_a[7], op_a} + {op_b[7], op_b};

  sequence s_add;
    quiet && op_valid && op_code == csfl_pkg::OP_ADD;
  endsequence

  sequence s_sub;
    quiet && op_valid && op_code == csfl_pkg::OP_SUB;
  endsequence

  sequence s_logic;
    quiet && op_valid && op_code == csfl_pkg::OP_LOGIC;
  endsequence

  sequence s_shift;
    quiet && op_valid && op_code == csfl_pkg::OP_SHIFT;
  endsequence

  sequence s_sel1;
    quiet && op_valid && op_code == csfl_pkg::OP_SB1;
  endsequence

  sequence s_sel0;
    quiet && op_valid && op_code == csfl_pkg::OP_SB0;
  endsequence

  a_load_write: assert property ( // [RQ2]
    (ce && wr_hit && !op_valid && !firq_begin)
      |=> flags == $past(reg_wdata))
    else $error("direct write not stored");

  a_add_carry: assert property ( // [RQ5]
    s_add |=> flags[`CSFL_C] == $past(add9[8]))
    else $error("add carry wrong");

  a_sub_borrow: assert property ( // [RQ5]
    s_sub |=> flags[`CSFL_C] == $past(op_a < op_b))
    else $error("subtract borrow wrong");

  a_add_ovf: assert property ( // [RQ10]
    s_add |=> flags[`CSFL_V] == $past(sadd[8] != sadd[7]))
    else $error("add overflow wrong");

  a_half_carry: assert property ( // [RQ13]
    s_add |=> flags[`CSFL_H] == $past(addn[4]))
    else $error("half carry wrong");

  a_decimal_mode: assert property ( // [RQ12]
    s_sub |=> flags[`CSFL_D] ##1 1'b1)
    else $error("subtract did not mark decimal flag");

  a_shift_carry: assert property ( // [RQ6]
    s_shift |=> flags[`CSFL_C] == $past(op_shout))
    else $error("shift carry wrong");

  a_logic_flags: assert property ( // [RQ4]
    s_logic |=> !flags[`CSFL_V]
      && flags[`CSFL_Z] == ($past(op_res) == 8'h00)
      && flags[`CSFL_S] == $past(op_res[7]))
    else $error("logic flags wrong");

  a_fis_set: assert property ( // [RQ14]
    (ce && firq_begin) |=> irq_block)
    else $error("fast status not set");

  a_fast_ret: assert property ( // [RQ15]
    (ce && is_interrupt_return && irq_block && !firq_begin && !wr_hit)
      |=> fast_return && !irq_block)
    else $error("fast return not taken");

  a_bank_seq: assert property ( // [RQ17]
    s_sel1 ##1 s_sel0 |=> !bank_sel && $past(bank_sel, 1))
    else $error("bank select sequence wrong");

  a_jump_carry: assert property ( // [RQ22]
    (ce && cc_valid && cc_field == `CSFL_CC_C)
      |=> jump_taken == $past(flags[`CSFL_C]))
    else $error("carry condition wrong");

  a_branch_tgt: assert property ( // [RQ20]
    ce |=> branch_target
      == 16'($past(fld_npc) + {{8{$past(fld_roff[7])}}, $past(fld_roff)}))
    else $error("branch target wrong");
endmodule
`default_nettype wire

// *** tb/csfl_top_test.sv ***
// self-checking bench of the cpu status flag logic
`timescale 1ns/1ns
`default_nettype none
module csfl_top_test;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic               clk, arst_n, ce, op_valid, op_shout, firq_begin;
  csfl_pkg::csfl_op_t op_code;
  logic [7:0]         op_a, op_b, op_res, reg_addr, reg_wdata, reg_rdata;
  logic               reg_wr, reg_rd, cc_valid, fld_long;
  logic [3:0]         cc_field, fld_wreg;
  logic [2:0]         fld_bit;
  logic [7:0]         fld_pair, fld_roff, fld_soff, flags, bit_mask;
  logic [15:0]        fld_npc, fld_ibase, fld_loff, wreg_sel;
  logic [15:0]        branch_target, index_addr;
  logic               bank_sel, irq_block, fast_return, collide;
  logic               jump_taken, pair_ok;
  int                 n_mismatch;
  int                 n_tests;
  logic [7:0]         vals [2] = '{8'ha0, 8'h50};

  csfl_top dut (
    .clk(clk), .arst_n(arst_n), .ce(ce), .op_valid(op_valid),
    .op_code(op_code), .op_a(op_a), .op_b(op_b), .op_res(op_res),
    .op_shout(op_shout), .firq_begin(firq_begin), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .cc_valid(cc_valid), .cc_field(cc_field),
    .fld_wreg(fld_wreg), .fld_bit(fld_bit), .fld_pair(fld_pair),
    .fld_roff(fld_roff), .fld_npc(fld_npc), .fld_ibase(fld_ibase),
    .fld_soff(fld_soff), .fld_loff(fld_loff), .fld_long(fld_long),
    .flags(flags), .bank_sel(bank_sel), .irq_block(irq_block),
    .fast_return(fast_return), .collide(collide),
    .jump_taken(jump_taken), .wreg_sel(wreg_sel), .bit_mask(bit_mask),
    .pair_ok(pair_ok), .branch_target(branch_target),
    .index_addr(index_addr)
  );

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic tick;
    @(negedge clk);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one operation, taken at the next rising edge; it stays applied
  // until the next call or idle, so back to back ops never drop valid
  task automatic op(input csfl_pkg::csfl_op_t c, input logic [7:0] a,
                    input logic [7:0] b, input logic [7:0] r,
                    input logic s);
    op_valid = 1'b1;
    op_code  = c;
    op_a     = a;
    op_b     = b;
    op_res   = r;
    op_shout = s;
    tick;
  endtask

  task automatic idle;
    op_valid = 1'b0;
    op_code  = csfl_pkg::OP_NOP;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    reg_wr    = 1'b1;
    reg_addr  = ad;
    reg_wdata = d;
    tick;
    reg_wr    = 1'b0;
  endtask

  // read data stands only one cycle, so it is looked at right away
  task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
    reg_rd   = 1'b1;
    reg_addr = ad;
    tick;
    reg_rd   = 1'b0;
    chk(reg_rdata, exp);
  endtask

  // own model of the condition table, cc[3] inverts
  function automatic logic cc_exp(input logic [7:0] f, input logic [3:0] c);
    logic t;
    case (c[2:0])
      3'h0: t = 1'b0;
      3'h1: t = f[5] ^ f[4];
      3'h2: t = f[6] | (f[5] ^ f[4]);
      3'h3: t = f[7] | f[6];
      3'h4: t = f[4];
      3'h5: t = f[5];
      3'h6: t = f[6];
      default: t = f[7];
    endcase
    return t ^ c[3];
  endfunction

  task automatic final_report;
    $display("mismatches=%0d comparisons=%0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ****************************************
  // clock and watchdog
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // about 70 cycles of tests, so 20000 cycles means a hang
  initial begin
    #2000000;
    n_mismatch++;
    final_report;
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    n_mismatch = 0;
    n_tests = 0;
    arst_n = 1'b0; ce = 1'b1; op_valid = 1'b0; op_code = csfl_pkg::OP_NOP;
    op_a = 8'h00; op_b = 8'h00; op_res = 8'h00; op_shout = 1'b0;
    firq_begin = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00;
    reg_wdata = 8'h00; cc_valid = 1'b0; cc_field = 4'h0; fld_wreg = 4'h0;
    fld_bit = 3'h0; fld_pair = 8'h00; fld_roff = 8'h00; fld_npc = 16'h0000;
    fld_ibase = 16'h0000; fld_soff = 8'h00; fld_loff = 16'h0000;
    fld_long = 1'b0;
    repeat (3) tick;
    chk(flags, 8'h00);
    arst_n = 1'b1;
    wr(8'hd5, 8'ha5);
    chk(flags, 8'ha5);
    rd(8'hd5, 8'ha5);
    wr(8'h10, 8'h00);
    chk(flags, 8'ha5);
    rd(8'h10, 8'h00);
    wr(8'hd5, 8'h00);
    op(csfl_pkg::OP_ADD, 8'hff, 8'h01, 8'h00, 1'b0);
    chk(flags, 8'hc4);
    op(csfl_pkg::OP_ADD, 8'h7f, 8'h01, 8'h80, 1'b0);
    chk(flags, 8'h34);
    op(csfl_pkg::OP_SUB, 8'h00, 8'h01, 8'hff, 1'b0);
    chk(flags, 8'hac);
    op(csfl_pkg::OP_SUB, 8'h80, 8'h01, 8'h7f, 1'b0);
    chk(flags, 8'h1c);
    op(csfl_pkg::OP_LOGIC, 8'h00, 8'h00, 8'h00, 1'b0);
    chk(flags, 8'h4c);
    op(csfl_pkg::OP_BTST, 8'h00, 8'h00, 8'h80, 1'b0);
    chk(flags, 8'h2c);
    // overflow after a shift is left open, so only c z s are seen
    op(csfl_pkg::OP_SHIFT, 8'h00, 8'h00, 8'h00, 1'b1);
    chk(flags & 8'he0, 8'hc0);
    op(csfl_pkg::OP_SHIFT, 8'h00, 8'h00, 8'h81, 1'b0);
    chk(flags & 8'he0, 8'h20);
    op(csfl_pkg::OP_SCF, 8'h00, 8'h00, 8'h00, 1'b0);
    chk(flags[7], 1'b1);
    op(csfl_pkg::OP_CCF, 8'h00, 8'h00, 8'h00, 1'b0);
    chk(flags[7], 1'b0);
    op(csfl_pkg::OP_CCF, 8'h00, 8'h00, 8'h00, 1'b0);
    chk(flags[7], 1'b1);
    op(csfl_pkg::OP_ADC, 8'h01, 8'h01, 8'h03, 1'b0);
    chk(flags, 8'h00);
    op(csfl_pkg::OP_RCF, 8'h00, 8'h00, 8'h00, 1'b0);
    chk(flags[7], 1'b0);
    op(csfl_pkg::OP_SCF, 8'h00, 8'h00, 8'h00, 1'b0);
    op(csfl_pkg::OP_SBC, 8'h00, 8'h00, 8'hff, 1'b0);
    chk(flags, 8'hac);
    op(csfl_pkg::OP_DADJ, 8'h00, 8'h00, 8'h00, 1'b0);
    chk(flags, 8'h4c);
    ce = 1'b0;
    op(csfl_pkg::OP_SCF, 8'h00, 8'h00, 8'h00, 1'b0);
    chk(flags, 8'h4c);
    ce = 1'b1;
    op(csfl_pkg::OP_SB1, 8'h00, 8'h00, 8'h00, 1'b0);
    chk({flags[0], bank_sel}, 2'b11);
    op(csfl_pkg::OP_SB0, 8'h00, 8'h00, 8'h00, 1'b0);
    chk({flags[0], bank_sel}, 2'b00);
    op(csfl_pkg::OP_INTERRUPT_RETURN, 8'h00, 8'h00, 8'h00, 1'b0);
    chk(fast_return, 1'b0);
    idle;
    firq_begin = 1'b1;
    tick;
    firq_begin = 1'b0;
    chk({flags[1], irq_block}, 2'b11);
    op(csfl_pkg::OP_INTERRUPT_RETURN, 8'h00, 8'h00, 8'h00, 1'b0);
    chk({fast_return, flags[1], irq_block}, 3'b100);
    reg_wr = 1'b1;
    reg_addr = 8'hd5;
    op(csfl_pkg::OP_LOGIC, 8'h00, 8'h00, 8'h00, 1'b0);
    reg_wr = 1'b0;
    idle;
    chk(collide, 1'b1);
    tick;
    chk(collide, 1'b0);
    fld_wreg = 4'hf; fld_bit = 3'h7; fld_pair = 8'hfe; fld_roff = 8'h80;
    fld_npc = 16'h0100; fld_ibase = 16'h1000; fld_soff = 8'h80;
    fld_loff = 16'hffff;
    tick;
    chk(wreg_sel, 16'h8000);
    chk(bit_mask, 8'h80);
    chk(pair_ok, 1'b1);
    chk(branch_target, 16'h0080);
    chk(index_addr, 16'h0f80);
    fld_wreg = 4'h0; fld_bit = 3'h0; fld_pair = 8'h0f; fld_roff = 8'h7f;
    fld_ibase = 16'h0001; fld_long = 1'b1;
    tick;
    chk(wreg_sel, 16'h0001);
    chk(bit_mask, 8'h01);
    chk(pair_ok, 1'b0);
    chk(branch_target, 16'h017f);
    chk(index_addr, 16'h0000);
    for (int v = 0; v < 2; v++) begin
      wr(8'hd5, vals[v]);
      cc_valid = 1'b1;
      for (int i = 0; i < 16; i++) begin
        cc_field = i[3:0];
        tick;
        chk(jump_taken, cc_exp(vals[v], i[3:0]));
      end
      cc_valid = 1'b0;
    end
    final_report;
  end
endmodule
`default_nettype wire
